// file: bench/fpx_exec_chk.sv
/*
 * Port-level checker for the floating-point execute block's bus side.
 * Assumes a single master, word transfers and hready tied to hreadyout.
 */
`timescale 1ns/100ps
module fpx_exec_chk
    import fpx_pkg::*;
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus inputs
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    // Bus outputs
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire            take = hsel & hready & htrans[1];
    logic           cw_q;
    logic    [31:0] ctrl_m_q;

    // Mirror of the control word, so a read-back can be judged
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cw_q     <= 1'b0;
            ctrl_m_q <= FPX_CTRL_RST;
        end
        else
        begin
            cw_q <= take & hwrite & (haddr[7:0] == FPX_OFF_CTRL);
            if (cw_q && hready)
                ctrl_m_q <= hwdata;
        end
    end

    // ************************************************************
    // Bus timing and content
    // ************************************************************
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("slave answered with an error");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_fast; take && hwrite |=> hreadyout [*2]; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write was stalled");
    property p_wait_cause; $fell(hreadyout) |-> $past(take && !hwrite); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("stall without a read");
    property p_rdata_hold; !$rose(hreadyout) |-> $stable(hrdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_gap_zero; take && !hwrite && haddr[7:0] > 8'h20 |-> ##2 hrdata == 32'h0; endproperty
    a_gap_zero: assert property (p_gap_zero) else $error("unmapped read not zero");
    property p_ctrl_echo;
        take && !hwrite && haddr[7:0] == FPX_OFF_CTRL |-> ##2 (hrdata & 32'h377) == (ctrl_m_q & 32'h377);
    endproperty
    a_ctrl_echo: assert property (p_ctrl_echo) else $error("enable bits lost");
    property p_one_wait; !hreadyout |=> hreadyout; endproperty
    a_one_wait: assert property (p_one_wait) else $error("stall longer than one cycle");
endmodule : fpx_exec_chk

bind fpx_exec fpx_exec_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// file: bench/tb_top.sv
/*
 * Self-checking bench: drives instruction words and operands over the bus.
 * Assumes the register map and execution timing of the package and notes.
 */
`timescale 1ns/100ps
module tb_top;
    import fpx_pkg::*;
    logic         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic  [31:0] haddr = 0, hwdata = 0, hrdata, s, v;
    logic   [1:0] htrans = 0;
    logic  [63:0] f;
    logic [127:0] cat;
    logic         tk, an;
    int           n_fail = 0, n_compared = 0;
    localparam logic [63:0] REL = 64'h7b3d_591f_84c2_a6e0;   // Relation mask per cond

    fpx_exec #(.FREGS(32)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    always #5 hclk = ~hclk;

    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Address phase held until hready seen high, then data phase likewise
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : rd
    task automatic setf(input logic [4:0] i, input logic [63:0] x);
        wr(FPX_OFF_FIDX, {27'h0, i}); wr(FPX_OFF_FHI, x[63:32]); wr(FPX_OFF_FLO, x[31:0]);
    endtask : setf
    task automatic getf(input logic [4:0] i, output logic [63:0] x);
        wr(FPX_OFF_FIDX, {27'h0, i}); rd(FPX_OFF_FHI, x[63:32]); rd(FPX_OFF_FLO, x[31:0]);
    endtask : getf
    task automatic run(input logic [31:0] ins, output logic [31:0] st);
        wr(FPX_OFF_INSTR, ins); rd(FPX_OFF_STATUS, st);
    endtask : run
    function automatic logic [31:0] fop(logic [5:0] o3, logic [8:0] opf, int d, int a, int b);
        return {2'h2, 5'(d), o3, 5'(a), opf, 5'(b)};
    endfunction : fop
    task final_report;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        #200000 n_fail++;
        final_report();
    end
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(FPX_OFF_CTRL, v); chk("ctrl reset", FPX_CTRL_RST, v);
        rd(FPX_OFF_STATUS, v); chk("status reset", 32'h0, v);
        rd(FPX_OFF_FSR, v); chk("fsr reset", FPX_FSR_RST, v);
        rd(8'h3c, v); chk("unmapped", 32'h0, v);
        // Unit disabled: trap and no status change
        wr(FPX_OFF_FSR, 32'h0001_c3ff); setf(1, 64'h8123_4567_89ab_cdef);
        run(fop(FPX_OP3_FPOP, FPX_OPF_ABS_D, 2, 0, 1), s); chk("off abs", 32'h12, s);
        run(32'h1180_0001, s); chk("off branch", 32'h12, s);
        rd(FPX_OFF_FSR, v); chk("off fsr", 32'h0001_c3ff, v);
        wr(FPX_OFF_CTRL, 32'h7);
        run(fop(FPX_OP3_FPOP, FPX_OPF_ABS_D, 2, 0, 1), s); chk("abs d", 32'h10, s);
        rd(FPX_OFF_FSR, v); chk("abs fsr", 32'h0000_03e0, v);
        getf(2, f); chk("abs d hi", 32'h0123_4567, f[63:32]);
        chk("abs d lo", 32'h89ab_cdef, f[31:0]);
        setf(3, 64'h8000_0000_ffff_ffff);
        run(fop(FPX_OP3_FPOP, FPX_OPF_ABS_S, 3, 0, 1), s); chk("abs s", 32'h10, s);
        getf(3, f); chk("abs s lo", 32'h09ab_cdef, f[31:0]);
        run(fop(FPX_OP3_FPOP, FPX_OPF_ABS_Q, 2, 0, 1), s); chk("abs q", 32'h11, s);
        run(fop(FPX_OP3_FPOP, FPX_OPF_ABS_D, 2, 1, 1), s); chk("abs rsv", 32'h11, s);
        wr(FPX_OFF_FSR, 32'h0);
        run(fop(FPX_OP3_FPOP, FPX_OPF_SUM_Q, 2, 1, 1), s); chk("add q", 32'h13, s);
        rd(FPX_OFF_FSR, v); chk("add q ftt", 32'h3, {29'h0, v[16:14]});
        run(fop(FPX_OP3_FPOP, FPX_OPF_SUM_D, 2, 1, 1), s); chk("add d", 32'h13, s);
        rd(FPX_OFF_FSR, v); chk("add d ftt", 32'h2, {29'h0, v[16:14]});
        // Half-ulp addend: result depends on rounding direction
        setf(4, 64'h3f80_0000); setf(5, 64'h3380_0000); setf(7, 64'h4000_0000);
        run(fop(FPX_OP3_FPOP, FPX_OPF_SUM_S, 6, 4, 7), s); chk("add ex", 32'h10, s);
        getf(6, f); chk("add exact", 32'h4040_0000, f[31:0]);
        // Zero operand is handed to software as unfinished
        setf(9, 64'h0);
        run(fop(FPX_OP3_FPOP, FPX_OPF_SUM_S, 6, 4, 9), s);
        chk("add zero", 32'h13, s);
        rd(FPX_OFF_FSR, v); chk("add zero ftt", 32'h2, {29'h0, v[16:14]});
        for (int r = 0; r < 4; r++)
        begin
            wr(FPX_OFF_FSR, {2'(r), 30'h0});
            run(fop(FPX_OP3_FPOP, FPX_OPF_SUM_S, 6, 4, 5), s);
            chk("add st", 32'h10, s);
            getf(6, f);
            chk("add rnd", (r == 2) ? 32'h3f80_0001 : 32'h3f80_0000, f[31:0]);
            rd(FPX_OFF_FSR, v); chk("add nx", 32'h1, {27'h0, v[4:0]});
        end
        // Every byte offset of the joined pair
        setf(1, 64'h0011_2233_4455_6677); setf(2, 64'h8899_aabb_ccdd_eeff);
        for (int o = 0; o < 8; o++)
        begin
            wr(FPX_OFF_CTRL, 32'h7 | (o << 4));
            run(fop(FPX_OP3_GFX, FPX_OPF_ALIGN, 8, 1, 2), s);
            chk("align st", 32'h10, s);
            cat = {64'h0011_2233_4455_6677, 64'h8899_aabb_ccdd_eeff} << (8 * o);
            getf(8, f); chk("align hi", cat[127:96], f[63:32]);
            chk("align lo", cat[95:64], f[31:0]);
        end
        // All conditions against all code values, both annul settings
        wr(FPX_OFF_PC, 32'h100);
        for (int c = 0; c < 16; c++)
            for (int k = 0; k < 8; k++)
            begin
                wr(FPX_OFF_CTRL, {22'h0, 2'(k >> 1), 8'h07});
                run({2'h0, 1'(k), 4'(c), 3'h6, 22'h3ffffd}, s);
                tk = (c == 8) || (c != 0 && REL[c * 4 + (k >> 1)]);
                an = (tk && c != 8) ? 1'b0 : 1'(k);
                chk("branch", {27'h0, 1'b1, an, tk, 2'h0}, s);
                rd(FPX_OFF_TARGET, v); chk("target", 32'hf4, v);
            end
        final_report();
    end
endmodule : tb_top

// file: src/fpx_exec.sv
/*
 * Floating-point decode and execute block behind an AHB-Lite slave.
 * Software loads operands into the register file, writes one instruction
 * word and reads back status, target and results.
 * Assumes a single AHB-Lite master, word transfers, hready = hreadyout.
 */
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module fpx_exec
    import fpx_pkg::*;
#(
    parameter int FREGS = 32
)(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Branch condition against the two-bit condition code
    function automatic logic fpx_cond_true(input logic [3:0] cond, input logic [1:0] fcc);
        logic e;
        logic l;
        logic g;
        logic u;
        e = (fcc == FPX_FCC_EQ);
        l = (fcc == FPX_FCC_LT);
        g = (fcc == FPX_FCC_GT);
        u = (fcc == FPX_FCC_UN);
        case (cond)
            4'h0:    fpx_cond_true = 1'b0;
            4'h8:    fpx_cond_true = 1'b1;
            4'h7:    fpx_cond_true = u;
            4'h6:    fpx_cond_true = g;
            4'h5:    fpx_cond_true = g | u;
            4'h4:    fpx_cond_true = l;
            4'h3:    fpx_cond_true = l | u;
            4'h2:    fpx_cond_true = l | g;
            4'h1:    fpx_cond_true = l | g | u;
            4'h9:    fpx_cond_true = e;
            4'ha:    fpx_cond_true = e | u;
            4'hb:    fpx_cond_true = e | g;
            4'hc:    fpx_cond_true = e | g | u;
            4'hd:    fpx_cond_true = e | l;
            4'he:    fpx_cond_true = e | l | u;
            default: fpx_cond_true = e | l | g;
        endcase
    endfunction : fpx_cond_true

    // Single-precision add of normal operands; result {incomplete, inexact, value}.
    // Zero, subnormal, infinite, NaN inputs and out-of-range results are left
    // to software: too rare to justify the area here.
    function automatic logic [33:0] fpx_sum_single(input logic [31:0] a,
                                                   input logic [31:0] b,
                                                   input logic [1:0]  rmode);
        logic [31:0] x;
        logic [31:0] y;
        logic [7:0]  dexp;
        logic [26:0] mx;
        logic [26:0] my;
        logic [27:0] sum;
        logic [8:0]  e;
        logic [4:0]  lz;
        logic        found;
        logic        grd;
        logic        rest;
        logic        inc;
        logic [24:0] rm;
        logic        unf;
        x = (a[30:0] < b[30:0]) ? b : a;
        y = (a[30:0] < b[30:0]) ? a : b;
        unf = (x[30:23] == 8'h00) || (x[30:23] == 8'hff)
            || (y[30:23] == 8'h00) || (y[30:23] == 8'hff);
        mx = {1'b1, x[22:0], 3'h0};
        my = {1'b1, y[22:0], 3'h0};
        dexp = x[30:23] - y[30:23];
        if (dexp > 8'd26)
            my = 27'h1;
        else
            my = (my >> dexp) | {26'h0, |(my & ((27'h1 << dexp) - 27'h1))};
        e = {1'b0, x[30:23]};
        lz = 5'h0;
        found = 1'b0;
        if (x[31] == y[31])
        begin
            sum = {1'b0, mx} + {1'b0, my};
            if (sum[27])
            begin
                sum = {1'b0, sum[27:2], sum[1] | sum[0]};
                e = e + 9'h1;
            end
        end
        else
        begin
            sum = {1'b0, mx} - {1'b0, my};
            for (int i = 26; i >= 0; i--)
            begin
                if (!found && sum[i])
                begin
                    found = 1'b1;
                    lz = 5'(26 - i);
                end
            end
            if (e <= {4'h0, lz})
                unf = 1'b1;
            sum = sum << lz;
            e = e - {4'h0, lz};
        end
        rm = {1'b0, sum[26:3]};
        grd = sum[2];
        rest = |sum[1:0];
        case (rmode)
            2'h0:    inc = grd & (rest | rm[0]);
            2'h1:    inc = 1'b0;
            2'h2:    inc = ~x[31] & (grd | rest);
            default: inc = x[31] & (grd | rest);
        endcase
        rm = rm + {24'h0, inc};
        if (rm[24])
        begin
            rm = rm >> 1;
            e = e + 9'h1;
        end
        if (e >= 9'hff)
            unf = 1'b1;
        if (sum[27:0] == 28'h0)
            fpx_sum_single = {unf, 1'b0, rmode == 2'h3, 31'h0};
        else
            fpx_sum_single = {unf, grd | rest, x[31], e[7:0], rm[22:0]};
    endfunction : fpx_sum_single

    // ************************************************************
    // State
    // ************************************************************
    fpx_bus_state_type bus_q;
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    logic [31:0] instr_q;
    logic        go_q;
    logic [31:0] ctrl_q;
    logic [31:0] fsr_q;
    logic [31:0] pc_q;
    logic [31:0] target_q;
    logic [1:0]  trap_q;
    logic        taken_q;
    logic        annul_q;
    logic        done_q;
    logic [4:0]  fidx_q;
    logic [63:0] freg [FREGS];
    logic [31:0] hrdata_q;
    logic        hreadyout_q;
    logic        hresp_q;

    // Address phase and instruction fields
    logic        addr_ok;
    logic        fpu_on;
    logic [1:0]  op;
    logic [4:0]  fd;
    logic [5:0]  op3;
    logic [4:0]  fs1;
    logic [4:0]  fs2;
    logic [8:0]  opf;
    logic [63:0] src1;
    logic [63:0] src2;
    logic [2:0]  align;
    logic [33:0] sum_s;

    assign addr_ok = hsel && hready && htrans[1];
    assign fpu_on  = ctrl_q[FPX_CTRL_FEF] && ctrl_q[FPX_CTRL_PEF]
                  && ctrl_q[FPX_CTRL_PRESENT];
    assign op      = instr_q[31:30];
    assign fd      = instr_q[29:25];
    assign op3     = instr_q[24:19];
    assign fs1     = instr_q[18:14];
    assign fs2     = instr_q[4:0];
    assign opf     = instr_q[13:5];
    assign src1    = freg[fs1];
    assign src2    = freg[fs2];
    assign align   = ctrl_q[FPX_CTRL_ALIGN +: 3];
    assign sum_s   = fpx_sum_single(src1[31:0], src2[31:0], fsr_q[FPX_ROUNDING_DIRECTION_FIELD +: 2]);

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;

    // ************************************************************
    // Bus slave
    // ************************************************************

    // Reads take one wait state so that a write just before is visible
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_q       <= FPX_BUS_IDLE;
            wr_pend_q   <= 1'b0;
            addr_q      <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h0;
            hresp_q     <= 1'b0;
        end
        else
        begin
            hresp_q <= 1'b0;                     // Always OKAY
            case (bus_q)
                FPX_BUS_IDLE:
                begin
                    wr_pend_q <= addr_ok && hwrite;
                    if (addr_ok)
                        addr_q <= haddr[7:0];
                    if (addr_ok && !hwrite)
                    begin
                        bus_q       <= FPX_BUS_RD_WAIT;
                        hreadyout_q <= 1'b0;
                    end
                end
                FPX_BUS_RD_WAIT:
                begin
                    bus_q       <= FPX_BUS_IDLE;
                    hreadyout_q <= 1'b1;
                    case (addr_q)
                        FPX_OFF_INSTR:  hrdata_q <= instr_q;
                        FPX_OFF_CTRL:   hrdata_q <= ctrl_q;
                        FPX_OFF_FSR:    hrdata_q <= fsr_q;
                        FPX_OFF_PC:     hrdata_q <= pc_q;
                        FPX_OFF_TARGET: hrdata_q <= target_q;
                        FPX_OFF_STATUS: hrdata_q <= {27'h0, done_q, annul_q, taken_q, trap_q};
                        FPX_OFF_FIDX:   hrdata_q <= {27'h0, fidx_q};
                        FPX_OFF_FHI:    hrdata_q <= freg[fidx_q][63:32];
                        FPX_OFF_FLO:    hrdata_q <= freg[fidx_q][31:0];
                        default:        hrdata_q <= 32'h0;
                    endcase
                end
                default: bus_q <= FPX_BUS_IDLE;
            endcase
        end
    end

    // Plain software registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q  <= FPX_CTRL_RST;
            pc_q    <= 32'h0;
            fidx_q  <= 5'h0;
            instr_q <= 32'h0;
            go_q    <= 1'b0;
        end
        else
        begin
            go_q <= wr_pend_q && (addr_q == FPX_OFF_INSTR);
            if (wr_pend_q)
            begin
                case (addr_q)
                    FPX_OFF_INSTR: instr_q <= hwdata;
                    FPX_OFF_CTRL:  ctrl_q  <= {22'h0, hwdata[9:8], 1'b0, hwdata[6:4],
                                               1'b0, hwdata[2:0]};
                    FPX_OFF_PC:    pc_q    <= hwdata;
                    FPX_OFF_FIDX:  fidx_q  <= hwdata[4:0];
                    default:       ;
                endcase
            end
        end
    end

    // ************************************************************
    // Execute
    // ************************************************************

    // Register file: software port and the execute write port
    always_ff @(posedge hclk)
    begin
        if (wr_pend_q && addr_q == FPX_OFF_FHI)
            freg[fidx_q][63:32] <= hwdata;
        else if (wr_pend_q && addr_q == FPX_OFF_FLO)
            freg[fidx_q][31:0] <= hwdata;
        else if (go_q && fpu_on && op == FPX_OP_ARITH)
        begin
            if (op3 == FPX_OP3_FPOP && opf == FPX_OPF_ABS_S && fs1 == 5'h0)
                freg[fd] <= {src2[63:32], 1'b0, src2[30:0]};
            else if (op3 == FPX_OP3_FPOP && opf == FPX_OPF_ABS_D && fs1 == 5'h0)
                freg[fd] <= {1'b0, src2[62:0]};
            else if (op3 == FPX_OP3_FPOP && opf == FPX_OPF_SUM_S && !sum_s[33])
                freg[fd] <= {src2[63:32], sum_s[31:0]};
            else if (op3 == FPX_OP3_GFX && opf == FPX_OPF_ALIGN)
                freg[fd] <= 64'({src1, src2} >> (7'd64 - {align, 3'h0}));
        end
    end

    // Status effects, traps and branch resolution
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fsr_q    <= FPX_FSR_RST;
            trap_q   <= FPX_TRAP_NONE;
            taken_q  <= 1'b0;
            annul_q  <= 1'b0;
            done_q   <= 1'b0;
            target_q <= 32'h0;
        end
        else if (wr_pend_q && addr_q == FPX_OFF_FSR)
            fsr_q <= hwdata & 32'hc001_c3ff;
        else if (go_q)
        begin
            done_q  <= 1'b1;
            trap_q  <= FPX_TRAP_NONE;
            taken_q <= 1'b0;
            annul_q <= 1'b0;
            target_q <= pc_q + {{8{instr_q[21]}}, instr_q[21:0], 2'h0};
            if (!((op == FPX_OP_BRANCH && instr_q[24:22] == FPX_OP2_FBR)
                  || (op == FPX_OP_ARITH && (op3 == FPX_OP3_FPOP || op3 == FPX_OP3_GFX))))
                trap_q <= FPX_TRAP_ILLEGAL;
            else if (!fpu_on)
                trap_q <= FPX_TRAP_FPU_OFF;
            else if (op == FPX_OP_BRANCH)
            begin
                if (instr_q[28:25] == 4'h8)
                begin
                    taken_q <= 1'b1;
                    annul_q <= instr_q[29];
                end
                else if (instr_q[28:25] == 4'h0)
                    annul_q <= instr_q[29];
                else if (fpx_cond_true(instr_q[28:25], ctrl_q[FPX_CTRL_FCC +: 2]))
                    taken_q <= 1'b1;
                else
                    annul_q <= instr_q[29];
            end
            else if (op3 == FPX_OP3_GFX)
            begin
                if (opf != FPX_OPF_ALIGN)
                    trap_q <= FPX_TRAP_ILLEGAL;
            end
            else if (opf == FPX_OPF_ABS_S || opf == FPX_OPF_ABS_D || opf == FPX_OPF_ABS_Q)
            begin
                if (opf == FPX_OPF_ABS_Q || fs1 != 5'h0)
                    trap_q <= FPX_TRAP_ILLEGAL;
                else
                begin
                    fsr_q[FPX_CURRENT_EXCEPTION_FIELD +: 5] <= 5'h0;
                    fsr_q[FPX_FP_TRAP_TYPE_FIELD +: 3]  <= FPX_FTT_NONE;
                end
            end
            else if (opf == FPX_OPF_SUM_Q)
            begin
                trap_q <= FPX_TRAP_MISC;
                fsr_q[FPX_FP_TRAP_TYPE_FIELD +: 3] <= FPX_FTT_MISSING;
            end
            else if (opf == FPX_OPF_SUM_D || (opf == FPX_OPF_SUM_S && sum_s[33]))
            begin
                trap_q <= FPX_TRAP_MISC;
                fsr_q[FPX_FP_TRAP_TYPE_FIELD +: 3] <= FPX_FTT_INCOMPLETE;
            end
            else if (opf == FPX_OPF_SUM_S)
            begin
                fsr_q[FPX_CURRENT_EXCEPTION_FIELD +: 5] <= {4'h0, sum_s[32]};
                fsr_q[FPX_ACCRUED_EXCEPTION_FIELD +: 5] <= fsr_q[FPX_ACCRUED_EXCEPTION_FIELD +: 5] | {4'h0, sum_s[32]};
                fsr_q[FPX_FP_TRAP_TYPE_FIELD +: 3]  <= FPX_FTT_NONE;
            end
            else
                trap_q <= FPX_TRAP_ILLEGAL;
        end
    end

endmodule : fpx_exec

// file: src/fpx_pkg.sv
/*
 * Shared constants of the floating-point decode and execute block:
 * register offsets, field positions, instruction encodings, trap codes.
 * Assumes a 32-bit AHB-Lite slave port with word accesses only.
 */
package fpx_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] FPX_OFF_INSTR   = 8'h00;
    localparam logic [7:0] FPX_OFF_CTRL    = 8'h04;
    localparam logic [7:0] FPX_OFF_FSR     = 8'h08;
    localparam logic [7:0] FPX_OFF_PC      = 8'h0c;
    localparam logic [7:0] FPX_OFF_TARGET  = 8'h10;
    localparam logic [7:0] FPX_OFF_STATUS  = 8'h14;
    localparam logic [7:0] FPX_OFF_FIDX    = 8'h18;
    localparam logic [7:0] FPX_OFF_FHI     = 8'h1c;
    localparam logic [7:0] FPX_OFF_FLO     = 8'h20;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int FPX_CTRL_FEF     = 0;   // fp_state_enable_bit
    localparam int FPX_CTRL_PEF     = 1;   // processor-state FPU enable
    localparam int FPX_CTRL_PRESENT = 2;   // FPU fitted
    localparam int FPX_CTRL_ALIGN   = 4;   // graphics_byte_offset_field, 3 bits
    localparam int FPX_CTRL_FCC     = 8;   // first_fp_condition_code, 2 bits
    localparam int FPX_CURRENT_EXCEPTION_FIELD     = 0;   // current_exception_field, 5 bits
    localparam int FPX_ACCRUED_EXCEPTION_FIELD     = 5;   // accrued_exception_field, 5 bits
    localparam int FPX_FP_TRAP_TYPE_FIELD      = 14;  // fp_trap_type_field, 3 bits
    localparam int FPX_ROUNDING_DIRECTION_FIELD       = 30;  // rounding_direction_field, 2 bits

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] FPX_CTRL_RST = 32'h0000_0004;
    localparam logic [31:0] FPX_FSR_RST  = 32'h0000_0000;

    // ************************************************************
    // Instruction encodings
    // ************************************************************
    localparam logic [1:0] FPX_OP_BRANCH   = 2'h0;
    localparam logic [1:0] FPX_OP_ARITH    = 2'h2;
    localparam logic [2:0] FPX_OP2_FBR     = 3'h6;
    localparam logic [5:0] FPX_OP3_FPOP    = 6'h34;
    localparam logic [5:0] FPX_OP3_GFX     = 6'h36;
    localparam logic [8:0] FPX_OPF_ABS_S   = 9'h009;
    localparam logic [8:0] FPX_OPF_ABS_D   = 9'h00a;
    localparam logic [8:0] FPX_OPF_ABS_Q   = 9'h00b;
    localparam logic [8:0] FPX_OPF_SUM_S   = 9'h041;
    localparam logic [8:0] FPX_OPF_SUM_D   = 9'h042;
    localparam logic [8:0] FPX_OPF_SUM_Q   = 9'h043;
    localparam logic [8:0] FPX_OPF_ALIGN   = 9'h048;

    // ************************************************************
    // Trap type field codes and trap kinds
    // ************************************************************
    localparam logic [2:0] FPX_FTT_NONE       = 3'h0;
    localparam logic [2:0] FPX_FTT_INCOMPLETE = 3'h2;   // incomplete_operation_code
    localparam logic [2:0] FPX_FTT_MISSING    = 3'h3;   // missing_operation_code
    localparam logic [1:0] FPX_TRAP_NONE      = 2'h0;
    localparam logic [1:0] FPX_TRAP_ILLEGAL   = 2'h1;
    localparam logic [1:0] FPX_TRAP_FPU_OFF   = 2'h2;   // fpu_off_trap
    localparam logic [1:0] FPX_TRAP_MISC      = 2'h3;   // fp_misc_trap

    // Condition code values
    localparam logic [1:0] FPX_FCC_EQ = 2'h0;
    localparam logic [1:0] FPX_FCC_LT = 2'h1;
    localparam logic [1:0] FPX_FCC_GT = 2'h2;
    localparam logic [1:0] FPX_FCC_UN = 2'h3;

    typedef enum logic [0:0] {FPX_BUS_IDLE, FPX_BUS_RD_WAIT} fpx_bus_state_type;

endpackage : fpx_pkg
